// *** cap_if.sv ***
interface cap_if;
  import cap_pkg::*;
  logic wr;
  cap_fields_t wdata;
  logic load;
  cap_fields_t report;
  cap_fields_t value;
  modport store (input wr, input wdata, input load, input report, output value);
  modport ctrl (output wr, output wdata, output load, output report, input value);
endinterface : cap_if

// *** cap_pkg.sv ***
package cap_pkg;
  // Register map
  localparam logic [7:0] CAP_ONE_ADDR = 8'h20;
  localparam logic [7:0] CAP_ONE_RESET = 8'h00;
  // Field positions inside the capability byte
  localparam int FREEZE_BIT = 7;
  localparam int MODE_LSB_BIT = 6;
  localparam int FREQ_REQ_BIT = 5;
  localparam int EQ_REQ_BIT = 4;
  localparam int TWO_LINK_BIT = 3;
  localparam int CHAN_ROLE_BIT = 2;
  localparam int FIELD_LSB = 2;
  localparam int FIELD_MSB = 7;
  localparam logic [1:0] LOW_BITS_ZERO = 2'h0;

  // Combined fast control channel mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_GPIO_ONE = 3'h1;
  localparam logic [2:0] MODE_GPIO_TWO = 3'h2;
  localparam logic [2:0] MODE_GPIO_FOUR = 3'h3;
  localparam logic [2:0] MODE_SPI_FWD = 3'h6;
  localparam logic [2:0] MODE_SPI_REV = 3'h7;
  localparam logic [2:0] GPIO_NONE = 3'h0;
  localparam logic [2:0] GPIO_ONE = 3'h1;
  localparam logic [2:0] GPIO_TWO = 3'h2;
  localparam logic [2:0] GPIO_FOUR = 3'h4;
  localparam logic [1:0] SPI_NONE = 2'h0;
  localparam logic [1:0] SPI_FWD = 2'h1;
  localparam logic [1:0] SPI_REV = 2'h2;

  // Bits 7..2 of the capability byte, msb first
  typedef struct packed {
    logic freeze;
    logic mode_lsb;
    logic freq_req;
    logic eq_req;
    logic two_link;
    logic chan_role;
  } cap_fields_t;

  localparam cap_fields_t CAP_FIELDS_RESET = cap_fields_t'(CAP_ONE_RESET[FIELD_MSB:FIELD_LSB]);
endpackage : cap_pkg

// *** cap_store.sv ***
module cap_store
  import cap_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  cap_if.store port
);
  typedef struct packed {
    cap_fields_t cap;
  } store_state_t;

  store_state_t q, d;

  // Software write beats an automatic load in the same cycle
  always_comb begin
    d = q;
    if (port.wr) begin
      d.cap = port.wdata;
    end else if (port.load && !q.cap.freeze) begin
      d.cap = port.report;
      d.cap.freeze = q.cap.freeze;
    end
  end

  // Synchronous reset to the documented default
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      q <= '{cap: CAP_FIELDS_RESET};
    end else begin
      q <= d;
    end
  end

  assign port.value = q.cap;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  frozen_hold_a: assert property (q.cap.freeze && !port.wr |=> $stable(q.cap))
    else $error("frozen capabilities changed without a write");
  auto_load_a: assert property (port.load && !q.cap.freeze && !port.wr
      |=> q.cap[FIELD_MSB-FIELD_LSB-1:0] == $past(port.report[FIELD_MSB-FIELD_LSB-1:0]))
    else $error("reported capabilities not loaded");
  sw_write_a: assert property (port.wr |=> q.cap == $past(port.wdata))
    else $error("software write not stored");
  freeze_kept_a: assert property (!port.wr |=> q.cap.freeze == $past(q.cap.freeze))
    else $error("freeze bit moved without a write");
  load_frozen_c: cover property (port.load && q.cap.freeze);
endmodule : cap_store

// *** remote_cap_partner.sv ***
module remote_cap_partner (
  input wire logic i_mclk,
  output logic [1:0] o_rx_lock,
  output logic [1:0] o_report_valid,
  output logic [4:0] o_report_link0,
  output logic [4:0] o_report_link1,
  output logic [1:0] o_mode_upper_link0,
  output logic [1:0] o_mode_upper_link1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Link starts unlocked with idle report lines
  initial begin
    o_rx_lock = 2'h0;
    o_report_valid = 2'h0;
    o_report_link0 = 5'h00;
    o_report_link1 = 5'h00;
    o_mode_upper_link0 = 2'h0;
    o_mode_upper_link1 = 2'h0;
  end
  // One report frame, then the lines scramble so no stale value lingers
  task automatic send(input logic lnk, input logic [4:0] caps);
    @(negedge i_mclk);
    o_report_valid[lnk] = 1'b1;
    if (lnk) o_report_link1 = caps;
    else o_report_link0 = caps;
    @(negedge i_mclk);
    o_report_valid[lnk] = 1'b0;
    o_report_link0 = ~o_report_link0;
    o_report_link1 = ~o_report_link1;
  endtask : send
  // Lock is a level owned by the far receiver
  task automatic set_lock(input logic [1:0] l);
    @(negedge i_mclk);
    o_rx_lock = l;
  endtask : set_lock
  // Upper mode bits come from the second capability byte
  task automatic set_mode(input logic [1:0] m0, input logic [1:0] m1);
    @(negedge i_mclk);
    o_mode_upper_link0 = m0;
    o_mode_upper_link1 = m1;
  endtask : set_mode
endmodule : remote_cap_partner

// *** remote_receiver_capability_reg.sv ***
// Contract
// - Freeze bit 7 set blocks automatic capability loads from the control channel.
// - While frozen, capability fields keep the values software last wrote.
// - Bit 6 is the low bit of the three-bit fast control mode.
// - After receive lock, reported remote capabilities load automatically unless frozen.
// - Bit 5 set makes the device send the frequency training pattern.
// - Bit 4 set makes the device send the equalization training pattern.
// - Bit 3 tells whether the remote receiver can run two links.
// - Bit 2 gives channel role: 0 primary channel 0, 1 secondary channel 1.
// - Second-port select makes register accesses reach the second link's copy.
// - All fields are software readable and writable and reset to zero.
// - Second-port select steers primary-address accesses; ignored with second address enabled.
// - Mode 000 normal, 001/010/011 one/two/four fast GPIOs, 110/111 forward/reverse SPI.
module remote_receiver_capability_reg
  import cap_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_reg_via_second_addr,
  input wire logic i_second_port_select,
  input wire logic i_second_host_address_enable,
  input wire logic [1:0] i_rx_lock,
  input wire logic [1:0] i_report_valid,
  input wire logic [4:0] i_report_link0,
  input wire logic [4:0] i_report_link1,
  input wire logic [1:0] i_mode_upper_link0,
  input wire logic [1:0] i_mode_upper_link1,
  output logic [7:0] o_reg_rdata,
  output logic [1:0] o_freq_training_request,
  output logic [1:0] o_eq_training_request,
  output logic [1:0] o_two_link_capable,
  output logic [1:0] o_chan_role,
  output logic [2:0] o_fast_gpio_count_link0,
  output logic [2:0] o_fast_gpio_count_link1,
  output logic [1:0] o_fast_spi_link0,
  output logic [1:0] o_fast_spi_link1
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0] freq;
    logic [1:0] eq;
    logic [1:0] two_link;
    logic [1:0] role;
    logic [2:0] gpio0;
    logic [2:0] gpio1;
    logic [1:0] spi0;
    logic [1:0] spi1;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    rdata: CAP_ONE_RESET, freq: 2'h0, eq: 2'h0, two_link: 2'h0, role: 2'h0,
    gpio0: GPIO_NONE, gpio1: GPIO_NONE, spi0: SPI_NONE, spi1: SPI_NONE
  };

  // Capability fields back into a register byte, low two bits unmapped here
  function automatic logic [7:0] cap_byte(input cap_fields_t c);
    cap_byte = {c, LOW_BITS_ZERO};
  endfunction : cap_byte

  // Number of fast GPIOs that a mode carries
  function automatic logic [2:0] gpio_count(input logic [2:0] mode);
    case (mode)
      MODE_GPIO_ONE: gpio_count = GPIO_ONE;
      MODE_GPIO_TWO: gpio_count = GPIO_TWO;
      MODE_GPIO_FOUR: gpio_count = GPIO_FOUR;
      default: gpio_count = GPIO_NONE;
    endcase
  endfunction : gpio_count

  // SPI direction of a mode; reserved codes give none
  function automatic logic [1:0] spi_kind(input logic [2:0] mode);
    case (mode)
      MODE_SPI_FWD: spi_kind = SPI_FWD;
      MODE_SPI_REV: spi_kind = SPI_REV;
      default: spi_kind = SPI_NONE;
    endcase
  endfunction : spi_kind

  // Which link's copy an access reaches
  function automatic logic pick_second(input logic via_second, input logic sel,
                                       input logic second_addr_en);
    pick_second = second_addr_en ? via_second : sel;
  endfunction : pick_second

  cap_if link0_bus ();
  cap_if link1_bus ();

  top_state_t q, d;
  logic hit_cap;
  logic to_second;
  logic [2:0] mode0;
  logic [2:0] mode1;

  // Address decode and port steering
  assign hit_cap = (i_reg_addr == CAP_ONE_ADDR);
  assign to_second = pick_second(i_reg_via_second_addr, i_second_port_select,
                                 i_second_host_address_enable);

  // Writes go to one link only; a write with freeze set protects it
  assign link0_bus.wr = i_reg_wr && hit_cap && !to_second;
  assign link1_bus.wr = i_reg_wr && hit_cap && to_second;
  assign link0_bus.wdata = cap_fields_t'(i_reg_wdata[FIELD_MSB:FIELD_LSB]);
  assign link1_bus.wdata = cap_fields_t'(i_reg_wdata[FIELD_MSB:FIELD_LSB]);

  // Reports only count while the link holds receive lock
  assign link0_bus.load = i_rx_lock[0] && i_report_valid[0];
  assign link1_bus.load = i_rx_lock[1] && i_report_valid[1];
  assign link0_bus.report = cap_fields_t'({1'b0, i_report_link0});
  assign link1_bus.report = cap_fields_t'({1'b0, i_report_link1});

  cap_store u_cap_store0 (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .port (link0_bus.store)
  );

  cap_store u_cap_store1 (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .port (link1_bus.store)
  );

  // Full mode: upper bits come from the second capability register
  assign mode0 = {i_mode_upper_link0, link0_bus.value.mode_lsb};
  assign mode1 = {i_mode_upper_link1, link1_bus.value.mode_lsb};

  // Next state of read data and link controls
  always_comb begin
    d = q;
    d.rdata = CAP_ONE_RESET;
    if (i_reg_rd && hit_cap) begin
      d.rdata = to_second ? cap_byte(link1_bus.value) : cap_byte(link0_bus.value);
    end
    d.freq = {link1_bus.value.freq_req, link0_bus.value.freq_req};
    d.eq = {link1_bus.value.eq_req, link0_bus.value.eq_req};
    d.two_link = {link1_bus.value.two_link, link0_bus.value.two_link};
    d.role = {link1_bus.value.chan_role, link0_bus.value.chan_role};
    d.gpio0 = gpio_count(mode0);
    d.gpio1 = gpio_count(mode1);
    d.spi0 = spi_kind(mode0);
    d.spi1 = spi_kind(mode1);
  end

  // Every output is a flop; outputs lag the stored fields by one cycle
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      q <= TOP_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_freq_training_request = q.freq;
  assign o_eq_training_request = q.eq;
  assign o_two_link_capable = q.two_link;
  assign o_chan_role = q.role;
  assign o_fast_gpio_count_link0 = q.gpio0;
  assign o_fast_gpio_count_link1 = q.gpio1;
  assign o_fast_spi_link0 = q.spi0;
  assign o_fast_spi_link1 = q.spi1;

  // Checks on steering, decode and output timing
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  reset_zero_a: assert property (disable iff (1'b0) !i_nrst |=> o_reg_rdata == CAP_ONE_RESET
      && o_freq_training_request == 2'h0 && o_eq_training_request == 2'h0)
    else $error("outputs not zero after reset");
  read_second_a: assert property (i_reg_rd && hit_cap && !i_second_host_address_enable
      && i_second_port_select |=> o_reg_rdata == cap_byte($past(link1_bus.value)))
    else $error("second port select did not read second copy");
  select_ignored_a: assert property (i_reg_rd && hit_cap && i_second_host_address_enable
      && !i_reg_via_second_addr && i_second_port_select
      |=> o_reg_rdata == cap_byte($past(link0_bus.value)))
    else $error("port select not ignored with second address on");
  write_steer_a: assert property (link0_bus.wr && !link1_bus.load
      |=> $stable(link1_bus.value) && link0_bus.value == $past(link0_bus.wdata))
    else $error("write reached the wrong link copy");
  freq_follow_a: assert property (link0_bus.value.freq_req
      |=> o_freq_training_request[0])
    else $error("frequency training not requested");
  eq_follow_a: assert property (link1_bus.value.eq_req
      |=> o_eq_training_request[1])
    else $error("equalization training not requested");
  caps_follow_a: assert property (##1 o_two_link_capable
      == {$past(link1_bus.value.two_link), $past(link0_bus.value.two_link)}
      && o_chan_role == {$past(link1_bus.value.chan_role), $past(link0_bus.value.chan_role)})
    else $error("capability outputs do not follow stored fields");
  gpio_decode_a: assert property (mode0 == MODE_GPIO_FOUR
      |=> o_fast_gpio_count_link0 == GPIO_FOUR && o_fast_spi_link0 == SPI_NONE)
    else $error("four gpio mode misdecoded");
  spi_decode_a: assert property (mode1 == MODE_SPI_REV
      |=> o_fast_spi_link1 == SPI_REV && o_fast_gpio_count_link1 == GPIO_NONE)
    else $error("reverse spi mode misdecoded");
  frozen_link_a: assert property (link0_bus.value.freeze && link0_bus.load && !link0_bus.wr
      |=> $stable(link0_bus.value))
    else $error("frozen link copy overwritten by load");
  mode_bit_a: assert property (i_reg_rd && hit_cap && !to_second
      |=> o_reg_rdata[MODE_LSB_BIT] == $past(link0_bus.value.mode_lsb))
    else $error("mode low bit not at bit six");

  read_second_c: cover property (i_reg_rd && hit_cap && to_second);
  write_freeze_c: cover property (link1_bus.wr && i_reg_wdata[FREEZE_BIT]);
  load_then_read_c: cover property (link0_bus.load ##1 i_reg_rd && hit_cap);
  spi_fwd_c: cover property (mode0 == MODE_SPI_FWD);
endmodule : remote_receiver_capability_reg

// *** test_remote_receiver_capability_reg.sv ***
module test_remote_receiver_capability_reg import cap_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, wr, rd, via, sel, hae;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] lock, rvalid, mup0, mup1, freq, eq, two, role, s0, s1, es;
  logic [4:0] rep0, rep1;
  logic [2:0] g0, g1, eg;
  int err_count = 0;
  int n_tests = 0;
  remote_receiver_capability_reg u_remote_receiver_capability_reg (
    .i_mclk(mclk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .i_reg_via_second_addr(via),
    .i_second_port_select(sel), .i_second_host_address_enable(hae),
    .i_rx_lock(lock), .i_report_valid(rvalid), .i_report_link0(rep0),
    .i_report_link1(rep1), .i_mode_upper_link0(mup0), .i_mode_upper_link1(mup1),
    .o_reg_rdata(rdata), .o_freq_training_request(freq), .o_eq_training_request(eq),
    .o_two_link_capable(two), .o_chan_role(role), .o_fast_gpio_count_link0(g0),
    .o_fast_gpio_count_link1(g1), .o_fast_spi_link0(s0), .o_fast_spi_link1(s1));
  remote_cap_partner u_remote_cap_partner (
    .i_mclk(mclk), .o_rx_lock(lock), .o_report_valid(rvalid), .o_report_link0(rep0),
    .o_report_link1(rep1), .o_mode_upper_link0(mup0), .o_mode_upper_link1(mup1));
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic final_report();
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Output levels against expectation
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected pins at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pin
  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic s);
    @(negedge mclk);
    addr = a;
    wdata = d;
    sel = s;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the read edge
  task automatic chk_rd(input logic [7:0] a, input logic s, input logic [7:0] exp);
    @(negedge mclk);
    addr = a;
    sel = s;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    n_tests++;
    if (rdata !== exp) begin
      err_count++;
      $display("unexpected read at %0t: got %h expected %h", $time, rdata, exp);
    end
  endtask : chk_rd
  // Tests take about 115 cycles; this 3000-cycle bound is generous
  initial begin
    #(25 * 3000);
    err_count++;
    final_report();
  end
  initial begin
    {addr, wdata, wr, rd, via, sel, hae, nrst} = '0;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    chk_rd(CAP_ONE_ADDR, 1'b0, CAP_ONE_RESET);
    chk_rd(CAP_ONE_ADDR, 1'b1, CAP_ONE_RESET);
    chk_pin({freq, eq, two, role}, 8'h00);
    // Per-copy storage, low bits dropped
    wr_reg(CAP_ONE_ADDR, 8'h3f, 1'b0);
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h3c);
    chk_rd(CAP_ONE_ADDR, 1'b1, 8'h00);
    chk_pin({freq, eq, two, role}, 8'h55);
    wr_reg(CAP_ONE_ADDR, 8'h14, 1'b1);
    chk_rd(CAP_ONE_ADDR, 1'b1, 8'h14);
    chk_pin({freq, eq, two, role}, 8'h77);
    wr_reg(8'h21, 8'hff, 1'b0);
    chk_rd(8'h21, 1'b0, 8'h00);
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h3c);
    // Reports load only under lock
    u_remote_cap_partner.send(1'b0, 5'h13);
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h3c);
    u_remote_cap_partner.set_lock(2'h3);
    u_remote_cap_partner.send(1'b0, 5'h13);
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h4c);
    chk_rd(CAP_ONE_ADDR, 1'b1, 8'h14);
    // Frozen override survives reports, other copy still loads
    wr_reg(CAP_ONE_ADDR, 8'ha4, 1'b0);
    u_remote_cap_partner.send(1'b0, 5'h0b);
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'ha4);
    u_remote_cap_partner.send(1'b1, 5'h0b);
    chk_rd(CAP_ONE_ADDR, 1'b1, 8'h2c);
    wr_reg(CAP_ONE_ADDR, 8'h24, 1'b0);
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h24);
    u_remote_cap_partner.send(1'b0, 5'h1f);
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h7c);
    // Secondary address flag overrides port select
    hae = 1'b1;
    wr_reg(CAP_ONE_ADDR, 8'h88, 1'b1);
    via = 1'b1;
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h2c);
    {hae, via} = 2'h0;
    chk_rd(CAP_ONE_ADDR, 1'b0, 8'h88);
    // Every combined mode code on link 0
    for (logic [3:0] m = 0; m < 8; m++) begin
      u_remote_cap_partner.set_mode(m[2:1], 2'h0);
      wr_reg(CAP_ONE_ADDR, {1'b1, m[0], 6'h00}, 1'b0);
      repeat (2) @(negedge mclk);
      eg = (m == 3) ? GPIO_FOUR : (m < 3) ? m[2:0] : GPIO_NONE;
      es = (m == 6) ? SPI_FWD : (m == 7) ? SPI_REV : SPI_NONE;
      chk_pin({3'h0, g0, s0}, {3'h0, eg, es});
    end
    u_remote_cap_partner.set_mode(2'h0, 2'h1);
    wr_reg(CAP_ONE_ADDR, 8'hc0, 1'b1);
    repeat (2) @(negedge mclk);
    chk_pin({3'h0, g1, s1}, {3'h0, GPIO_FOUR, SPI_NONE});
    // Reset in mid-run clears both copies
    nrst = 1'b0;
    @(negedge mclk);
    nrst = 1'b1;
    chk_rd(CAP_ONE_ADDR, 1'b0, CAP_ONE_RESET);
    chk_rd(CAP_ONE_ADDR, 1'b1, CAP_ONE_RESET);
    chk_pin({freq, eq, two, role}, 8'h00);
    final_report();
  end
endmodule : test_remote_receiver_capability_reg
